/* siss_top.sv */
/*
  Switch input scan sequencer: continuous and standard polling scans over
  twenty-four inputs, result storage, change detection and the alert line.
  Assumes a same-clock sampler answers each request with sample_ack, and the
  host interface pulses int_stat_read when the interrupt status is read.
*/
`include "siss_cfg.svh"
module siss_top
  import siss_pkg::*;
#(
  parameter logic [`SISS_TMR_W-1:0] STARTUP_US  = 16'(`SISS_STARTUP_US),
  parameter logic [`SISS_TMR_W-1:0] ACT_BASE_US = 16'(`SISS_ACT_BASE_US),
  parameter logic [`SISS_PER_W-1:0] PER_BASE_US = 23'(`SISS_PER_BASE_MS * `SISS_MS_US)
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 scan_start,
  input  wire logic                                 poll_mode,
  input  wire logic                                 poll_scheme,
  input  wire logic [`SISS_CFG_W-1:0]               wetting_level_cfg_a,
  input  wire logic [`SISS_CFG_W-1:0]               wetting_level_cfg_b,
  input  wire logic [`SISS_NCH-1:0]                 input_enable,
  input  wire logic [`SISS_NCH-1:0]                 input_mode,
  input  wire logic [`SISS_NCH-1:0]                 int_enable,
  input  wire logic [2:0]                           wetting_window_len,
  input  wire logic [3:0]                           poll_period_sel,
  input  wire logic                                 int_stat_read,
  input  wire logic                                 sample_ack,
  input  wire siss_rsp_t                            sample_rsp,
  output      logic                                 sample_req_ff,
  output      siss_req_t                            sample_sel_ff,
  output      logic [`SISS_NCH-1:0]                 wetting_en_ff,
  output      logic [`SISS_NCH-1:0][`SISS_LVL_W-1:0] wetting_level_ff,
  output      logic [`SISS_NCH-1:0]                 comp_status_ff,
  output      logic [`SISS_NCH-1:0]                 adc_threshold_result_ff,
  output      logic [`SISS_NCH-1:0][`SISS_ADC_W-1:0] analog_value_ff,
  output      logic                                 status_change_flag_ff,
  output      logic                                 alert_n_ff
);

  siss_state_t                  state_ff;
  logic [`SISS_DIV_W-1:0]       div_ff;
  logic                         us_tick_ff;
  logic [`SISS_TMR_W-1:0]       tmr_ff;
  logic [`SISS_PER_W-1:0]       per_ff;
  logic [`SISS_CH_W-1:0]        ch_ff;
  logic                         first_ff;
  logic                         start_d_ff;
  logic [`SISS_NCH-1:0]         zero_mask;
  logic [`SISS_NCH-1:0]         on_mask;
  logic [`SISS_NCH-1:0]         nxt_wet;
  logic [`SISS_TMR_W-1:0]       act_us;
  logic [`SISS_PER_W-1:0]       period_us;
  logic [`SISS_CH_W-1:0]        first_chan;
  logic [`SISS_CH_W-1:0]        nxt_chan;
  logic                         start_rise;
  logic                         cycle_begin;
  logic                         sample_fire;
  logic                         ack_now;
  logic                         cycle_end;
  logic                         ref_bit;
  logic                         changed;
  logic                         set_evt;

  // Level code of one input from the two packed level fields
  function automatic logic [`SISS_LVL_W-1:0] level_of(input int ch);
    if (ch < `SISS_HALF_CH)
      level_of = wetting_level_cfg_a[ch*`SISS_LVL_W +: `SISS_LVL_W];
    else
      level_of = wetting_level_cfg_b[(ch-`SISS_HALF_CH)*`SISS_LVL_W +: `SISS_LVL_W];
  endfunction : level_of

  // Lowest enabled input at or above from; NONE when there is none
  function automatic logic [`SISS_CH_W-1:0] next_ch(input logic [`SISS_CH_W-1:0] from);
    next_ch = `SISS_NONE;
    for (int i = `SISS_NCH-1; i >= 0; i--) begin
      if (i >= int'(from) && input_enable[i])
        next_ch = 5'(i);
    end
  endfunction : next_ch

  // Per-input level decode and the set of inputs that may carry current
  always_comb begin
    for (int i = 0; i < `SISS_NCH; i++) begin
      zero_mask[i] = (level_of(i) == SISS_LVL_0MA);
    end
    on_mask = input_enable & ~zero_mask;
  end

  // Programmed window and period; out-of-range selects clamp to the longest
  assign act_us = (wetting_window_len > `SISS_ACT_SEL_MAX) ?
                  (ACT_BASE_US << `SISS_ACT_SEL_MAX) : (ACT_BASE_US << wetting_window_len);
  assign period_us = (poll_period_sel > `SISS_PER_SEL_MAX) ?
                     (PER_BASE_US << `SISS_PER_SEL_MAX) : (PER_BASE_US << poll_period_sel);

  // Sequencing events shared by the processes below
  assign start_rise  = scan_start && !start_d_ff;
  assign first_chan  = next_ch(5'h00);
  assign nxt_chan    = next_ch(5'(ch_ff + 5'h01));
  assign cycle_begin = us_tick_ff &&
                       ((state_ff == SISS_STARTUP && tmr_ff >= STARTUP_US - 16'h0001) ||
                        (state_ff == SISS_WAITP && per_ff >= period_us - 23'h000001));
  assign sample_fire = (state_ff == SISS_WET) &&
                       (!poll_mode || (us_tick_ff && tmr_ff >= act_us - 16'h0001));
  assign ack_now     = (state_ff == SISS_SAMPLE) && sample_ack;
  assign cycle_end   = (ack_now && nxt_chan == `SISS_NONE) ||
                       (cycle_begin && first_chan == `SISS_NONE);

  // Stored reference of the input just answered, chosen by its mode
  assign ref_bit = sample_sel_ff.use_adc ? adc_threshold_result_ff[sample_sel_ff.ch]
                                         : comp_status_ff[sample_sel_ff.ch];
  assign changed = ack_now && !first_ff && (ref_bit != sample_rsp.above);
  assign set_evt = (changed && int_enable[sample_sel_ff.ch]) || (cycle_end && first_ff);

  // Microsecond enable; long waits count ticks instead of clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff     <= 5'h00;
      us_tick_ff <= 1'b0;
    end else if (div_ff == 5'(`SISS_CYC_PER_US - 1)) begin
      div_ff     <= 5'h00;
      us_tick_ff <= 1'b1;
    end else begin
      div_ff     <= 5'(div_ff + 5'h01);
      us_tick_ff <= 1'b0;
    end
  end

  // Edge detect on the scan start bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      start_d_ff <= 1'b0;
    else
      start_d_ff <= scan_start;
  end

  // Scan sequencer; dropping scan start aborts at once and removes current
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SISS_IDLE;
      ch_ff    <= 5'h00;
      tmr_ff   <= 16'h0000;
    end else if (!scan_start) begin
      state_ff <= SISS_IDLE;
    end else begin
      unique case (state_ff)
        SISS_IDLE: begin
          if (start_rise) begin
            state_ff <= SISS_STARTUP;
            tmr_ff   <= 16'h0000;
          end
        end
        SISS_STARTUP, SISS_WAITP: begin
          if (cycle_begin) begin
            ch_ff    <= first_chan;
            tmr_ff   <= 16'h0000;
            state_ff <= (first_chan == `SISS_NONE) ? SISS_WAITP : SISS_WET;
          end else if (us_tick_ff && state_ff == SISS_STARTUP) begin
            tmr_ff <= 16'(tmr_ff + 16'h0001);
          end
        end
        SISS_WET: begin
          if (sample_fire)
            state_ff <= SISS_SAMPLE;
          else if (us_tick_ff)
            tmr_ff <= 16'(tmr_ff + 16'h0001);
        end
        SISS_SAMPLE: begin
          if (ack_now) begin
            tmr_ff <= 16'h0000;
            if (nxt_chan == `SISS_NONE) begin
              state_ff <= SISS_WAITP;
            end else begin
              ch_ff    <= nxt_chan;
              state_ff <= SISS_WET;
            end
          end
        end
        default: state_ff <= SISS_IDLE;
      endcase
    end
  end

  // Period timer restarts with each cycle, so inputs are revisited once a period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      per_ff <= 23'h000000;
    else if (cycle_begin)
      per_ff <= 23'h000000;
    else if (us_tick_ff && per_ff != {`SISS_PER_W{1'b1}})
      per_ff <= 23'(per_ff + 23'h000001);
  end

  // First-cycle marker: set on scan start, cleared as the first cycle closes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      first_ff <= 1'b0;
    else if (state_ff == SISS_IDLE && start_rise)
      first_ff <= 1'b1;
    else if (cycle_end)
      first_ff <= 1'b0;
  end

  // Current switches: all live inputs in continuous mode, one window at a time when polling;
  // matrix scheme is not built here, so either scheme select runs standard polling
  always_comb begin
    nxt_wet = '0;
    if (state_ff == SISS_WET || state_ff == SISS_SAMPLE || state_ff == SISS_WAITP) begin
      if (!poll_mode)
        nxt_wet = on_mask;
      else if (state_ff != SISS_WAITP && poll_scheme == poll_scheme)
        nxt_wet = on_mask & (24'h000001 << ch_ff);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      wetting_en_ff <= '0;
    else
      wetting_en_ff <= nxt_wet;
  end

  // Level codes handed to the current sources for every input
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wetting_level_ff <= '0;
    end else begin
      for (int i = 0; i < `SISS_NCH; i++)
        wetting_level_ff[i] <= level_of(i);
    end
  end

  // Sample request: a one-cycle pulse, with channel and route held until the next
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_req_ff <= 1'b0;
      sample_sel_ff <= '0;
    end else begin
      sample_req_ff <= sample_fire;
      if (sample_fire) begin
        sample_sel_ff.ch      <= ch_ff;
        sample_sel_ff.use_adc <= input_mode[ch_ff];
      end
    end
  end

  // Result store; only window samples land here, so changes between windows vanish
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_status_ff          <= '0;
      adc_threshold_result_ff <= '0;
      analog_value_ff         <= '0;
    end else if (ack_now) begin
      if (sample_sel_ff.use_adc) begin
        adc_threshold_result_ff[sample_sel_ff.ch] <= sample_rsp.above;
        analog_value_ff[sample_sel_ff.ch]         <= sample_rsp.code;
      end else begin
        comp_status_ff[sample_sel_ff.ch] <= sample_rsp.above;
      end
    end
  end

  // Change flag and alert line; a new event wins over a read in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_change_flag_ff <= 1'b0;
      alert_n_ff            <= 1'b1;
    end else if (set_evt) begin
      status_change_flag_ff <= 1'b1;
      alert_n_ff            <= 1'b0;
    end else if (int_stat_read) begin
      status_change_flag_ff <= 1'b0;
      alert_n_ff            <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  alert_tracks_flag_a: assert property (
    alert_n_ff == !status_change_flag_ff)
    else $error("alert line and change flag disagree");

  read_releases_a: assert property (
    int_stat_read && !set_evt |=> alert_n_ff && !status_change_flag_ff)
    else $error("status read did not release alert");

  first_cycle_int_a: assert property (
    cycle_end && first_ff |=> !alert_n_ff && !first_ff)
    else $error("no alert after first cycle");

  change_alerts_a: assert property (
    changed && int_enable[sample_sel_ff.ch] |=> status_change_flag_ff)
    else $error("enabled change did not set flag");

  quiet_no_alert_a: assert property (
    alert_n_ff && !set_evt |=> alert_n_ff)
    else $error("alert fell without a cause");

  poll_one_on_a: assert property (
    poll_mode && $stable(poll_mode) |-> $onehot0(wetting_en_ff))
    else $error("more than one current on while polling");

  zero_level_off_a: assert property (
    (wetting_en_ff & zero_mask) == '0)
    else $error("current on a zero-level input");

  poll_sample_wet_a: assert property (
    sample_req_ff && poll_mode && $stable(poll_mode) && on_mask[sample_sel_ff.ch]
    |-> wetting_en_ff[sample_sel_ff.ch])
    else $error("polled sample taken with its current off");

  req_single_a: assert property (
    sample_req_ff |=> !sample_req_ff)
    else $error("sample request longer than one cycle");

  start_wait_a: assert property (
    state_ff == SISS_STARTUP |-> wetting_en_ff == '0)
    else $error("current on during startup delay");

endmodule : siss_top

/* siss_cfg.svh */
/*
  Constants for the switch input scan sequencer: channel counts, field widths,
  the no-channel code and timing figures. Assumes a 25 MHz system clock.
*/
`ifndef SISS_CFG_SVH
`define SISS_CFG_SVH
`define SISS_NCH          24
`define SISS_HALF_CH      12
`define SISS_CH_W         5
`define SISS_LVL_W        3
`define SISS_ADC_W        10
`define SISS_CFG_W        36
`define SISS_NONE         5'h18
`define SISS_US_NS        1000
`define SISS_CLK_NS       40
`define SISS_CYC_PER_US   (`SISS_US_NS / `SISS_CLK_NS)
`define SISS_DIV_W        5
`define SISS_TMR_W        16
`define SISS_PER_W        23
`define SISS_ACT_BASE_US  64
`define SISS_ACT_SEL_MAX  3'h5
`define SISS_PER_BASE_MS  2
`define SISS_MS_US        1000
`define SISS_PER_SEL_MAX  4'hB
`define SISS_STARTUP_US   100
`endif

/* siss_pkg.sv */
/*
  Types for the switch input scan sequencer: states, level codes and the
  sample request and answer carriers. Assumes siss_cfg.svh is on the include path.
*/
`include "siss_cfg.svh"
package siss_pkg;
  typedef enum logic [2:0] {
    SISS_IDLE    = 3'h0,
    SISS_STARTUP = 3'h1,
    SISS_WET     = 3'h2,
    SISS_SAMPLE  = 3'h3,
    SISS_WAITP   = 3'h4
  } siss_state_t;

  typedef enum logic [`SISS_LVL_W-1:0] {
    SISS_LVL_0MA  = 3'h0,
    SISS_LVL_1MA  = 3'h1,
    SISS_LVL_2MA  = 3'h2,
    SISS_LVL_5MA  = 3'h3,
    SISS_LVL_10MA = 3'h4,
    SISS_LVL_15MA = 3'h5
  } siss_lvl_t;

  typedef struct packed {
    logic [`SISS_CH_W-1:0] ch;
    logic                  use_adc;
  } siss_req_t;

  typedef struct packed {
    logic                   above;
    logic [`SISS_ADC_W-1:0] code;
  } siss_rsp_t;
endpackage : siss_pkg

/* siss_sampler_model.sv */
/*
  Behavioural sampler and switch bank on the far side of the sample port.
  Assumes the bench drives the switch levels, the codes and the answer latency.
*/
module siss_sampler_model
  import siss_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             sample_req,
  input  wire siss_req_t        sample_sel,
  input  wire logic [23:0]      sw_above,
  input  wire logic [23:0][9:0] sw_code,
  input  wire logic [1:0]       lat,
  output      logic             sample_ack,
  output      siss_rsp_t        sample_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       busy_ff;
  logic [1:0] wait_ff;

  // Answer after 0 to 3 idle cycles; data toggles when not valid so stale values never match
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff    <= 1'b0;
      wait_ff    <= 2'h0;
      sample_ack <= 1'b0;
      sample_rsp <= '0;
    end else begin
      sample_ack <= 1'b0;
      sample_rsp <= ~sample_rsp;
      if ((sample_req && lat == 2'h0) || (busy_ff && wait_ff == 2'h0)) begin
        busy_ff          <= 1'b0;
        sample_ack       <= 1'b1;
        sample_rsp.above <= sw_above[sample_sel.ch];
        // Comparator route gets a scrambled code, so a wrong bank store shows up
        sample_rsp.code  <= sample_sel.use_adc ? sw_code[sample_sel.ch] : ~sw_code[sample_sel.ch];
      end else if (sample_req) begin
        busy_ff <= 1'b1;
        wait_ff <= lat - 2'h1;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule : siss_sampler_model

/* siss_top_tb_top.sv */
/*
  Self-checking bench for the scan sequencer: continuous and polling scans.
  Assumes siss_cfg.svh on the include path and the sampler model beside it.
*/
`include "siss_cfg.svh"
module siss_top_tb_top
  import siss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        first;
    logic [15:0] per;
    logic [4:0]  ch;
    logic        adc;
  } siss_exp_t;
  logic sys_clk, rst_n, scan_start, poll_mode, poll_scheme, int_stat_read;
  logic sample_ack, sample_req_ff, status_change_flag_ff, alert_n_ff;
  logic [35:0]      cfg_a, cfg_b;
  logic [23:0]      en, mode, inten, sw_above, wetting_en_ff, we_prev;
  logic [23:0]      comp_status_ff, adc_threshold_result_ff;
  logic [23:0][9:0] sw_code, analog_value_ff;
  logic [23:0][2:0] wetting_level_ff;
  logic [2:0]       win_len;
  logic [3:0]       per_sel;
  logic [1:0]       lat;
  siss_rsp_t        sample_rsp;
  siss_req_t        sample_sel_ff;
  int               n_fail, checked;
  longint           cyc, t_first, on_cnt;
  siss_exp_t        exp_q[$];

  siss_top #(.STARTUP_US(16'h2), .ACT_BASE_US(16'h2), .PER_BASE_US(23'h14)) i_siss_top (
    .sys_clk, .rst_n, .scan_start, .poll_mode, .poll_scheme,
    .wetting_level_cfg_a(cfg_a), .wetting_level_cfg_b(cfg_b), .input_enable(en),
    .input_mode(mode), .int_enable(inten), .wetting_window_len(win_len),
    .poll_period_sel(per_sel), .int_stat_read, .sample_ack, .sample_rsp, .sample_req_ff,
    .sample_sel_ff, .wetting_en_ff, .wetting_level_ff, .comp_status_ff,
    .adc_threshold_result_ff, .analog_value_ff, .status_change_flag_ff, .alert_n_ff);
  siss_sampler_model i_siss_sampler_model (.sys_clk, .rst_n, .sample_req(sample_req_ff),
    .sample_sel(sample_sel_ff), .sw_above, .sw_code, .lat, .sample_ack, .sample_rsp);

  always #20 sys_clk = ~sys_clk;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  function automatic logic [2:0] lvl(input int i);
    return (i < 12) ? cfg_a[3*i +: 3] : cfg_b[3*(i-12) +: 3];
  endfunction : lvl

  function automatic logic [23:0] lvl_mask();
    logic [23:0] m;
    for (int i = 0; i < 24; i++) m[i] = (lvl(i) != 3'h0);
    return m;
  endfunction : lvl_mask

  task automatic chk_alert(input logic low);
    cmp(alert_n_ff, !low);
    cmp(status_change_flag_ff, low);
  endtask : chk_alert

  // Note the requests of one scan, then wait until the monitor has seen them all
  task automatic run_cycle(input logic [15:0] per);
    siss_exp_t e;
    logic      f;
    int        k;
    f = 1'b1;
    for (int i = 0; i < 24; i++) if (en[i]) begin
      e = '{first: f, per: per, ch: 5'(i), adc: mode[i]};
      exp_q.push_back(e);
      f = 1'b0;
    end
    k = 0;
    while (exp_q.size() != 0 && k < 6000) begin
      step(1);
      k++;
    end
    cmp(32'(exp_q.size()), 32'h0);
    exp_q.delete();
    // Slowest answer lands four edges after the last request; flag and store follow it
    step(6);
  endtask : run_cycle

  task automatic status_check();
    for (int i = 0; i < 24; i++) if (en[i]) begin
      if (mode[i]) begin
        cmp(adc_threshold_result_ff[i], sw_above[i]);
        cmp(analog_value_ff[i], sw_code[i]);
      end else cmp(comp_status_ff[i], sw_above[i]);
    end
  endtask : status_check

  task automatic clear_int();
    int_stat_read = 1'b1;
    step(1);
    int_stat_read = 1'b0;
    step(1);
    chk_alert(1'b0);
  endtask : clear_int

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Cycle count and length of the present wetting pattern, for window timing
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    on_cnt <= (wetting_en_ff != we_prev) ? 0 : on_cnt + 1;
    we_prev <= wetting_en_ff;
  end

  // Answer latency varies so both prompt and slow answers are seen
  always @(posedge sys_clk) begin
    #2 lat = 2'($urandom_range(3));
  end

  // Monitor: each request is matched against the oldest note
  always @(posedge sys_clk) begin
    siss_exp_t e;
    longint    act;
    act = (64'd2 << win_len) * 25;
    if (rst_n && sample_req_ff) begin
      if (exp_q.size() == 0) cmp(32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        cmp({sample_sel_ff.ch, sample_sel_ff.use_adc}, {e.ch, e.adc});
        if (e.first) begin
          if (e.per != 16'h0) cmp(32'(cyc - t_first), e.per);
          t_first = cyc;
        end
        if (poll_mode) begin
          cmp(wetting_en_ff, 24'h1 << e.ch);
          cmp(on_cnt >= act - 30 && on_cnt <= act + 5, 1'b1);
        end else cmp(wetting_en_ff, en & lvl_mask());
      end
    end
  end

  // Watchdog against a hung scan
  initial begin
    repeat (60000) @(posedge sys_clk);
    cmp(32'h0, 32'h1);
    summarize();
  end

  initial begin
    {sys_clk, rst_n, scan_start, poll_mode, poll_scheme, int_stat_read} = 6'h0;
    {cfg_a, cfg_b, en, mode, sw_above, sw_code} = '0;
    {win_len, per_sel, lat, n_fail, checked, cyc, on_cnt, we_prev, t_first} = '0;
    inten = '1;
    void'($urandom(12));
    repeat (8) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    // Continuous scan over a random set with random levels, modes and values
    en = 24'($urandom) | 24'h1;
    mode = 24'($urandom);
    sw_above = 24'($urandom);
    poll_scheme = 1'($urandom);
    per_sel = 4'h1;
    for (int i = 0; i < 24; i++) sw_code[i] = 10'($urandom);
    for (int i = 0; i < 12; i++) cfg_a[3*i +: 3] = 3'($urandom_range(5));
    for (int i = 0; i < 12; i++) cfg_b[3*i +: 3] = 3'($urandom_range(5));
    step(1);
    for (int i = 0; i < 24; i++) cmp(wetting_level_ff[i], lvl(i));
    scan_start = 1'b1;
    run_cycle(16'h0);
    chk_alert(1'b1);
    status_check();
    clear_int();
    run_cycle(16'd1000);
    chk_alert(1'b0);
    sw_above[0] = ~sw_above[0];
    run_cycle(16'd1000);
    chk_alert(1'b1);
    status_check();
    clear_int();
    $display("test continuous done");
    // Abort, then standard polling at full current
    scan_start = 1'b0;
    step(2);
    cmp(wetting_en_ff, 24'h0);
    poll_mode = 1'b1;
    cfg_a = {12{3'h5}};
    cfg_b = {12{3'h5}};
    win_len = 3'($urandom_range(1));
    per_sel = 4'h3;
    step(1);
    scan_start = 1'b1;
    run_cycle(16'h0);
    chk_alert(1'b1);
    status_check();
    clear_int();
    sw_above[0] = ~sw_above[0];
    run_cycle(16'd4000);
    chk_alert(1'b1);
    clear_int();
    inten[0] = 1'b0;
    sw_above[0] = ~sw_above[0];
    run_cycle(16'd4000);
    chk_alert(1'b0);
    status_check();
    inten = '1;
    sw_above[0] = ~sw_above[0];
    step(200);
    sw_above[0] = ~sw_above[0];
    run_cycle(16'd4000);
    chk_alert(1'b0);
    status_check();
    $display("test polling done");
    summarize();
  end
endmodule : siss_top_tb_top
